// ===== dacif_pkg.sv
// Register map, field layout and constants of the converter digital interface
package dacif_pkg;
  localparam int DACIF_ADDR_W = 8;
  localparam int DACIF_DATA_W = 32;
  localparam int DACIF_SAMPLE_W = 10;
  localparam int DACIF_NUM_TRIG = 6;

  localparam logic [7:0] DACIF_OFF_CONTROL = 8'h00;
  localparam logic [7:0] DACIF_OFF_MODE = 8'h04;
  localparam logic [7:0] DACIF_OFF_HOLDING = 8'h08;
  localparam logic [7:0] DACIF_OFF_OUTPUT = 8'h0c;
  localparam logic [7:0] DACIF_OFF_STATUS = 8'h10;
  localparam logic [7:0] DACIF_OFF_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] DACIF_OFF_IRQ_DISABLE = 8'h18;
  localparam logic [7:0] DACIF_OFF_IRQ_MASK = 8'h1c;
  localparam logic [7:0] DACIF_OFF_EVENTS = 8'h20;

  // Control register
  localparam int DACIF_SOFT_RESET_BIT = 0;

  // Mode register
  localparam int DACIF_TRIG_EN_BIT = 0;
  localparam int DACIF_TRIG_SEL_LSB = 1;
  localparam int DACIF_TRIG_SEL_W = 3;
  localparam int DACIF_RES_BIT = 4;
  localparam int DACIF_MODE_W = 5;
  localparam logic [4:0] DACIF_MODE_RESET = 5'h00;

  // 8-bit mode shift
  localparam int DACIF_NARROW_W = 8;
  localparam int DACIF_NARROW_SHIFT = 2;

  // Status, mask and event layout
  localparam int DACIF_READY_BIT = 0;
  localparam int DACIF_XFER_EV_BIT = 1;
  localparam int DACIF_OVWR_EV_BIT = 2;
  localparam int DACIF_IRQ_W = 3;
  localparam logic [2:0] DACIF_IRQ_RESET = 3'h0;
  localparam logic [9:0] DACIF_SAMPLE_RESET = 10'h000;
endpackage : dacif_pkg

// ===== dacif_rise_detect.sv
// Two-flop synchroniser with rising edge pulse for one asynchronous trigger
`timescale 1ns/1ps
`default_nettype none
module dacif_rise_detect (
  input wire logic clk,
  input wire logic rst,
  input wire logic async_in,
  output logic rise
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign rise = sync_q & ~last_q;
endmodule : dacif_rise_detect
`default_nettype wire

// ===== dacif_top.sv
// Converter digital interface: registers, sample transfer and trigger logic
//
// Behaviour
// (R01) Control bit 0 write one: soft reset
// (R02) Trigger off: copy holding one cycle later
// (R03) Trigger on: transfer only on selected trigger
// (R04) Select field picks timer 0..5; 11x reserved
// (R05) Resolution bit: 8-bit shifts data left two
// (R06) Software writes samples right-aligned in 9:0
// (R07) Holding reads shifted value, upper bits zero
// (R08) Output register reads current sample, zero-extended
// (R09) Ready flag 0 while write awaits transfer
// (R10) Ready flag 1 after latest sample transferred
// (R11) Ready flag 0 at reset, trigger off
// (R12) Enabling trigger sets ready flag
// (R13) Every selected rising edge transfers latest holding
// (R14) Ready interrupt gated by enable/disable mask
// (R15) Resets clear registers, pending (soft reset keeps the IRQ mask); reserved no transfer
`timescale 1ns/1ps
`default_nettype none
module dacif_top
  import dacif_pkg::*;
#(
  parameter int SAMPLE_W = DACIF_SAMPLE_W,
  parameter int NUM_TRIG = DACIF_NUM_TRIG
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [DACIF_ADDR_W-1:0] reg_addr,
  input wire logic [DACIF_DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [DACIF_DATA_W-1:0] reg_rdata,
  input wire logic timer_out_a_ch0,
  input wire logic timer_out_a_ch1,
  input wire logic timer_out_a_ch2,
  input wire logic timer_out_a_ch3,
  input wire logic timer_out_a_ch4,
  input wire logic timer_out_a_ch5,
  output logic [SAMPLE_W-1:0] sample_code,
  output logic irq
);
  if (SAMPLE_W != DACIF_SAMPLE_W) begin : g_bad_width
    $error("dacif_top: sample width must be 10");
  end
  if (NUM_TRIG < 1 || NUM_TRIG > DACIF_NUM_TRIG) begin : g_bad_trig
    $error("dacif_top: trigger count must be 1 to 6");
  end

  logic [DACIF_NUM_TRIG-1:0] timer_in;
  logic [DACIF_NUM_TRIG-1:0] timer_rise;
  logic [DACIF_MODE_W-1:0] mode_q;
  logic [SAMPLE_W-1:0] holding_q;
  logic [SAMPLE_W-1:0] output_q;
  logic pending_q;
  logic ready_q;
  logic [DACIF_IRQ_W-1:0] mask_q;
  logic [DACIF_IRQ_W-1:0] events_q;
  logic [DACIF_DATA_W-1:0] rdata_q;
  logic [DACIF_DATA_W-1:0] rdata_d;
  logic soft_rst;
  logic blk_rst;
  logic wr_control;
  logic wr_mode;
  logic wr_holding;
  logic wr_ier;
  logic wr_idr;
  logic wr_events;
  logic trig_en;
  logic [DACIF_TRIG_SEL_W-1:0] trig_sel;
  logic trig_fire;
  logic do_xfer;
  logic [SAMPLE_W-1:0] wr_sample;
  logic [DACIF_IRQ_W-1:0] ev_set;
  logic [DACIF_IRQ_W-1:0] irq_src;

  assign timer_in = {timer_out_a_ch5, timer_out_a_ch4, timer_out_a_ch3,
                     timer_out_a_ch2, timer_out_a_ch1, timer_out_a_ch0};

  // Only the channels in use are synchronised; the others never fire
  for (genvar i = 0; i < DACIF_NUM_TRIG; i++) begin : g_trig
    if (i < NUM_TRIG) begin : g_used
      dacif_rise_detect u_rise (
        .clk(clk),
        .rst(rst),
        .async_in(timer_in[i]),
        .rise(timer_rise[i])
      );
    end else begin : g_unused
      assign timer_rise[i] = 1'b0;
    end
  end

  assign wr_control = reg_write && (reg_addr == DACIF_OFF_CONTROL);
  assign wr_mode = reg_write && (reg_addr == DACIF_OFF_MODE);
  assign wr_holding = reg_write && (reg_addr == DACIF_OFF_HOLDING);
  assign wr_ier = reg_write && (reg_addr == DACIF_OFF_IRQ_ENABLE);
  assign wr_idr = reg_write && (reg_addr == DACIF_OFF_IRQ_DISABLE);
  assign wr_events = reg_write && (reg_addr == DACIF_OFF_EVENTS);

  assign soft_rst = wr_control && reg_wdata[DACIF_SOFT_RESET_BIT]; // R01
  assign blk_rst = rst || soft_rst; // R15

  assign trig_en = mode_q[DACIF_TRIG_EN_BIT];
  assign trig_sel = mode_q[DACIF_TRIG_SEL_LSB +: DACIF_TRIG_SEL_W];

  // Out-of-range select codes, including 11x, never fire
  always_comb begin
    trig_fire = 1'b0;
    if (trig_en && (int'(trig_sel) < DACIF_NUM_TRIG)) begin // R04 R15
      trig_fire = timer_rise[trig_sel];
    end
  end

  // Immediate path: pending one cycle after the write; trigger path on edges
  assign do_xfer = trig_en ? trig_fire : pending_q; // R02 R03 R13

  always_comb begin
    if (mode_q[DACIF_RES_BIT]) begin
      wr_sample = {reg_wdata[DACIF_NARROW_W-1:0],
                   {DACIF_NARROW_SHIFT{1'b0}}}; // R05
    end else begin
      wr_sample = reg_wdata[SAMPLE_W-1:0]; // R06
    end
  end

  always_ff @(posedge clk) begin
    if (blk_rst) begin
      mode_q <= DACIF_MODE_RESET;
    end else if (wr_mode) begin
      mode_q <= reg_wdata[DACIF_MODE_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (blk_rst) begin
      holding_q <= DACIF_SAMPLE_RESET;
    end else if (wr_holding) begin
      holding_q <= wr_sample; // R05
    end
  end

  always_ff @(posedge clk) begin
    if (blk_rst) begin
      pending_q <= 1'b0;
    end else begin
      pending_q <= wr_holding && !trig_en; // R02
    end
  end

  always_ff @(posedge clk) begin
    if (blk_rst) begin
      output_q <= DACIF_SAMPLE_RESET;
    end else if (do_xfer) begin
      output_q <= holding_q; // R02 R03 R13
    end
  end

  // A write in the same cycle as a trigger leaves the new sample waiting
  always_ff @(posedge clk) begin
    if (blk_rst) begin
      ready_q <= 1'b0; // R11
    end else if (wr_mode) begin
      ready_q <= reg_wdata[DACIF_TRIG_EN_BIT]; // R11 R12
    end else if (!trig_en) begin
      ready_q <= 1'b0; // R11
    end else if (wr_holding) begin
      ready_q <= 1'b0; // R09
    end else if (trig_fire) begin
      ready_q <= 1'b1; // R10
    end
  end

  // Sticky events: each transfer, and a waiting sample overwritten in trigger mode
  always_comb begin
    ev_set = '0;
    ev_set[DACIF_XFER_EV_BIT] = do_xfer;
    ev_set[DACIF_OVWR_EV_BIT] = wr_holding && trig_en && !ready_q;
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clk) begin
    if (blk_rst) begin
      events_q <= DACIF_IRQ_RESET;
    end else begin
      events_q <= (events_q & ~(wr_events ? reg_wdata[DACIF_IRQ_W-1:0] : '0)) | ev_set;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mask_q <= DACIF_IRQ_RESET;
    end else if (wr_ier) begin
      mask_q <= mask_q | reg_wdata[DACIF_IRQ_W-1:0]; // R14
    end else if (wr_idr) begin
      mask_q <= mask_q & ~reg_wdata[DACIF_IRQ_W-1:0]; // R14
    end
  end

  always_comb begin
    irq_src = events_q;
    irq_src[DACIF_READY_BIT] = ready_q;
  end

  assign irq = |(irq_src & mask_q); // R14

  always_comb begin
    rdata_d = '0;
    case (reg_addr)
      DACIF_OFF_MODE: rdata_d[DACIF_MODE_W-1:0] = mode_q;
      DACIF_OFF_HOLDING: rdata_d[SAMPLE_W-1:0] = holding_q; // R07
      DACIF_OFF_OUTPUT: rdata_d[SAMPLE_W-1:0] = output_q; // R08
      DACIF_OFF_STATUS: rdata_d[DACIF_READY_BIT] = ready_q; // R09 R10
      DACIF_OFF_IRQ_MASK: rdata_d[DACIF_IRQ_W-1:0] = mask_q;
      DACIF_OFF_EVENTS: rdata_d[DACIF_IRQ_W-1:0] = events_q;
      default: rdata_d = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= '0;
    end else if (reg_read) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= '0;
    end
  end

  assign reg_rdata = rdata_q;
  assign sample_code = output_q;
endmodule : dacif_top
`default_nettype wire

// ===== dacif_checker.sv
// Port-level assertions for the converter interface
`timescale 1ns/1ps
`default_nettype none
module dacif_checker
  import dacif_pkg::*;
#(parameter int SAMPLE_W = 10) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic [SAMPLE_W-1:0] sample_code,
  input wire logic irq
);
  logic [4:0] mode_q;
  logic wm, wh, sr;
  assign wm = reg_write && reg_addr == 8'h04;
  assign wh = reg_write && reg_addr == 8'h08;
  assign sr = reg_write && reg_addr == 8'h00 && reg_wdata[0];
  // Shadow of the mode register
  always_ff @(posedge clk) begin
    if (rst || sr) mode_q <= 5'h00;
    else if (wm) mode_q <= reg_wdata[4:0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_soft_clear: assert property (sr |=> sample_code == '0)
    else $error("output kept");
  a_direct_copy: assert property (wh && !mode_q[0] && !mode_q[4] ##1 !reg_write
    |=> sample_code == $past(reg_wdata[9:0], 2)) else $error("direct copy");
  a_narrow_shift: assert property (wh && !mode_q[0] && mode_q[4] ##1 !reg_write
    |=> sample_code == {$past(reg_wdata[7:0], 2), 2'b00}) else $error("narrow");
  a_output_read: assert property (reg_read && reg_addr == 8'h0c
    |=> reg_rdata == {22'h0, $past(sample_code)}) else $error("output read");
  a_ready_off: assert property (reg_read && reg_addr == 8'h10 && !mode_q[0]
    |=> reg_rdata == '0) else $error("ready off");
  a_ready_enable: assert property (wm && reg_wdata[0] ##1 reg_read && reg_addr == 8'h10
    |=> reg_rdata == 32'h1) else $error("ready on");
  a_irq_masked: assert property (reg_write && reg_addr == 8'h18
    && reg_wdata[2:0] == 3'h7 |=> !irq) else $error("irq");
  a_reserved_hold: assert property (mode_q[0] && mode_q[3:2] == 2'b11
    && !reg_write && !$past(reg_write) |=> $stable(sample_code)) else $error("reserved");
endmodule : dacif_checker
bind dacif_top dacif_checker #(.SAMPLE_W(SAMPLE_W)) chk (.clk(clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .sample_code(sample_code), .irq(irq));
`default_nettype wire

// ===== dacif_timer_model.sv
// Timer channel outputs in waveform mode
`timescale 1ns/1ps
`default_nettype none
module dacif_timer_model (
  input wire logic clk,
  output logic [5:0] tio
);
  initial tio = 6'h00;
  task automatic pulse(input logic [5:0] m);
    @(posedge clk);
    tio <= m;
    repeat (3) @(posedge clk);
    tio <= 6'h00;
  endtask : pulse
endmodule : dacif_timer_model
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the converter interface
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t %h %h", $time, g, e); end end
module tb_top
  import dacif_pkg::*;
;
  logic clk = 0, rst = 1, reg_write = 0, reg_read = 0, irq;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic [9:0] sample_code, exp_out = 10'h000;
  logic [5:0] tio;
  int errors = 0, compares = 0, seed = 12, cyc = 0, v;
  initial forever #12.5 clk = ~clk;
  dacif_timer_model tmr (.clk(clk), .tio(tio));
  dacif_top dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .timer_out_a_ch0(tio[0]), .timer_out_a_ch1(tio[1]), .timer_out_a_ch2(tio[2]),
    .timer_out_a_ch3(tio[3]), .timer_out_a_ch4(tio[4]), .timer_out_a_ch5(tio[5]),
    .sample_code(sample_code), .irq(irq));
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= w;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask : rd
  task automatic complete_run;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      errors++;
      complete_run();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (v = 1; v < 10; v++) rd(8'(4 * v), 0);
    for (v = 0; v < 8; v++) begin
      wr(8'h04, {27'h0, v[2], 4'h0});
      d = $random(seed);
      wr(8'h08, {22'h0, d[9:0]});
      exp_out = v[2] ? {d[7:0], 2'b00} : d[9:0];
      rd(8'h08, {22'h0, exp_out});
      `CHK(sample_code, exp_out)
      rd(8'h0c, {22'h0, exp_out});
      rd(8'h10, 0);
    end
    for (v = 0; v < 8; v++) begin
      wr(8'h04, 32'(v * 2 + 1));
      rd(8'h10, 1);
      d = $random(seed);
      wr(8'h08, {22'h0, d[9:0]});
      rd(8'h10, 0);
      tmr.pulse(6'h3f ^ (6'h01 << v));
      repeat (3) @(posedge clk);
      #1 `CHK(sample_code, exp_out)
      if (v < 6) exp_out = d[9:0];
      tmr.pulse(6'h01 << v);
      repeat (3) @(posedge clk);
      #1 `CHK(sample_code, exp_out)
      rd(8'h10, {31'h0, v < 6});
    end
    wr(8'h14, 1);
    rd(8'h1c, 1);
    wr(8'h04, 1);
    #1 `CHK(irq, 1'b1)
    wr(8'h18, 7);
    #1 `CHK(irq, 1'b0)
    wr(8'h00, 0);
    rd(8'h04, 1);
    wr(8'h00, 1);
    rd(8'h04, 0);
    `CHK(sample_code, 10'h000)
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
